// *** hdl/ubd_descriptor_engine.sv ***
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module ubd_descriptor_engine
  import ubd_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [ubd_pkg::WORD_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [ubd_pkg::WORD_W-1:0] regRdata,
  input wire logic tokReq,
  input wire logic [3:0] tokEp,
  input wire logic tokTx,
  input wire logic [3:0] tokPid,
  input wire logic tokToggle,
  output logic respValid,
  output ubd_pkg::ubd_resp_t respCode,
  output logic [ubd_pkg::ADDR_W-1:0] respBufAddr,
  output logic [ubd_pkg::COUNT_W-1:0] respCount,
  output logic respToggle,
  input wire logic doneReq,
  input wire logic [ubd_pkg::COUNT_W-1:0] doneCount,
  input wire logic [3:0] donePid,
  output logic memReq,
  output logic memWe,
  output logic [ubd_pkg::ADDR_W-1:0] memAddr,
  output logic [ubd_pkg::WORD_W-1:0] memWdata,
  input wire logic memAck,
  input wire logic [ubd_pkg::WORD_W-1:0] memRdata,
  output logic hostTokenGo,
  output logic [3:0] hostTokenPid,
  output logic [3:0] hostTokenEp,
  output logic busy
);
  import ubd_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] tableBasePointer;
  logic [2:0] moduleConfigOne;
  logic [NUM_EP-1:0] endpointStallFlag;
  logic [3:0] lastEndpointField;
  logic lastTx;
  logic lastOdd;
  logic ppFlush;

  wire wrTableBase = regWr && (regAddr == REG_TABLE_BASE);
  wire wrConfig = regWr && (regAddr == REG_CONFIG_ONE);
  wire wrHostToken = regWr && (regAddr == REG_HOST_TOKEN);
  wire wrStall = regWr && (regAddr == REG_STALL_FLAGS);
  wire wrControl = regWr && (regAddr == REG_CONTROL);
  wire hostMode = moduleConfigOne[CFG_HOST_POS];
  wire ubd_pp_mode_t ppMode = ubd_pp_mode_t'(moduleConfigOne[1:0]);
  wire [WORD_W-1:0] transferStatusReg = {8'h00, lastEndpointField, lastTx, lastOdd, 2'b00};

  wire [WORD_W-1:0] readMux =
    (regAddr == REG_TABLE_BASE) ? {8'h00, tableBasePointer} :
    (regAddr == REG_CONFIG_ONE) ? {13'h0000, moduleConfigOne} :
    (regAddr == REG_XFER_STATUS) ? transferStatusReg :
    (regAddr == REG_HOST_TOKEN) ? {8'h00, hostTokenPid, hostTokenEp} :
    (regAddr == REG_STALL_FLAGS) ? WORD_W'(endpointStallFlag) :
    {WORD_W{1'b0}};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tableBasePointer <= TABLE_BASE_RESET;
    end else if (wrTableBase) begin
      tableBasePointer <= regWdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      moduleConfigOne <= CONFIG_RESET;
    end else if (wrConfig) begin
      moduleConfigOne <= regWdata[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hostTokenPid <= HOST_TOKEN_RESET[7:4];
      hostTokenEp <= HOST_TOKEN_RESET[3:0];
      hostTokenGo <= 1'b0;
    end else begin
      hostTokenGo <= wrHostToken;
      if (wrHostToken) begin
        hostTokenPid <= regWdata[7:4];
        hostTokenEp <= regWdata[3:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ppFlush <= 1'b0;
    end else begin
      ppFlush <= wrControl && regWdata[CTRL_PP_RESET_POS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      regRdata <= {WORD_W{1'b0}};
    end else if (regRd) begin
      regRdata <= readMux;
    end else begin
      regRdata <= {WORD_W{1'b0}};
    end
  end

  // ----------------------------------------
  // Descriptor index and address
  // ----------------------------------------
  ubd_state_t state;
  ubd_state_t next_state;
  logic [3:0] curEp;
  logic curTx;
  logic [3:0] curPid;
  logic curToggle;
  logic [WORD_W-1:0] statusWord;
  logic [INDEX_W-1:0] descIndex;
  logic ppAble;
  logic [2*NUM_EP-1:0] oddBits;

  wire [3:0] mapEp = hostMode ? 4'h0 : (state == ST_IDLE) ? tokEp : curEp;
  wire [4:0] ppSel = {(state == ST_IDLE) ? tokTx : curTx, mapEp};
  wire curOdd = oddBits[ppSel];

  ubd_index_map u_map (
    .ppMode(ppMode),
    .ep(mapEp),
    .tx(ppSel[4]),
    .odd(curOdd),
    .index(descIndex),
    .ppAble(ppAble)
  );

  wire [ADDR_W-1:0] tableBase = {tableBasePointer[7:1], {TABLE_ALIGN_BITS{1'b0}}};
  wire [ADDR_W-1:0] descBase = tableBase + {8'h00, descIndex, 2'b00};
  wire [ADDR_W-1:0] statAddr = descBase + STATUS_WORD_OFS;
  wire [ADDR_W-1:0] bufWordAddr = descBase + ADDR_WORD_OFS;

  // ----------------------------------------
  // Descriptor decode
  // ----------------------------------------
  // shared owner bit
  wire ownedByModule = memRdata[OWNER_POS];
  wire stallHit = memRdata[STALL_EN_POS];
  wire toggleBad = memRdata[TOGGLE_CHECK_POS] && !curTx && (memRdata[TOGGLE_POS] != curToggle);
  wire statDone = (state == ST_RD_STAT) && memAck;
  wire addrDone = (state == ST_RD_ADDR) && memAck;
  wire wrDone = (state == ST_WR_STAT) && memAck;
  // status rewritten with PID and count
  wire [3:0] reportPid = hostMode ? donePid : curPid;
  wire [WORD_W-1:0] writeBack = {1'b0, curToggle, reportPid, doneCount};
  wire ubd_resp_t statVerdict = !ownedByModule ? RESP_NAK : stallHit ? RESP_STALL : toggleBad ? RESP_DROP : RESP_ACK;

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (tokReq) begin
          next_state = ST_RD_STAT;
        end
      end
      ST_RD_STAT: begin
        if (memAck) begin
          next_state = (statVerdict == RESP_ACK) ? ST_RD_ADDR : ST_RESP;
        end
      end
      ST_RD_ADDR: begin
        if (memAck) begin
          next_state = ST_RESP;
        end
      end
      ST_RESP: begin
        next_state = (respCode == RESP_ACK) ? ST_WAIT_DONE : ST_IDLE;
      end
      ST_WAIT_DONE: begin
        if (doneReq) begin
          next_state = ST_WR_STAT;
        end
      end
      ST_WR_STAT: begin
        if (memAck) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      curEp <= 4'h0;
      curTx <= 1'b0;
      curPid <= 4'h0;
      curToggle <= 1'b0;
    end else if ((state == ST_IDLE) && tokReq) begin
      curEp <= tokEp;
      curTx <= tokTx;
      curPid <= tokPid;
      curToggle <= tokToggle;
    end
  end

  // ----------------------------------------
  // DMA master
  // ----------------------------------------
  // own port reads status
  always_ff @(posedge core_clk) begin
    if (srst) begin
      memReq <= 1'b0;
      memWe <= 1'b0;
      memAddr <= {ADDR_W{1'b0}};
      memWdata <= {WORD_W{1'b0}};
    end else if ((next_state == ST_RD_STAT) && (state != ST_RD_STAT)) begin
      memReq <= 1'b1;
      memWe <= 1'b0;
      memAddr <= statAddr;
    end else if ((next_state == ST_RD_ADDR) && (state != ST_RD_ADDR)) begin
      memReq <= 1'b1;
      memWe <= 1'b0;
      memAddr <= bufWordAddr;
    end else if ((next_state == ST_WR_STAT) && (state != ST_WR_STAT)) begin
      memReq <= 1'b1;
      memWe <= 1'b1;
      memAddr <= statAddr;
      memWdata <= writeBack;
    end else if (memAck) begin
      memReq <= 1'b0;
      memWe <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      statusWord <= {WORD_W{1'b0}};
      respCode <= RESP_ACK;
    end else if (statDone) begin
      statusWord <= memRdata;
      respCode <= statVerdict;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      respBufAddr <= {ADDR_W{1'b0}};
    end else if (addrDone) begin
      respBufAddr <= memRdata;
    end
  end

  // ----------------------------------------
  // Answer to the serial engine
  // ----------------------------------------
  // count and toggle from status word
  always_ff @(posedge core_clk) begin
    if (srst) begin
      respValid <= 1'b0;
      respCount <= {COUNT_W{1'b0}};
      respToggle <= 1'b0;
    end else begin
      respValid <= (next_state == ST_RESP) && (state != ST_RESP);
      if (statDone) begin
        respCount <= memRdata[COUNT_W-1:0];
        respToggle <= memRdata[TOGGLE_POS];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != ST_IDLE);
    end
  end

  // ----------------------------------------
  // Stall flags and transfer status
  // ----------------------------------------
  wire stallSet = statDone && (statVerdict == RESP_STALL);
  wire [NUM_EP-1:0] stallSetVec = stallSet ? (NUM_EP'(1) << mapEp) : {NUM_EP{1'b0}};
  wire [NUM_EP-1:0] stallClrVec = wrStall ? regWdata[NUM_EP-1:0] : {NUM_EP{1'b0}};

  // stall flag set wins over clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      endpointStallFlag <= {NUM_EP{1'b0}};
    end else begin
      endpointStallFlag <= (endpointStallFlag & ~stallClrVec) | stallSetVec;
    end
  end

  // source endpoint in status bits 7:4
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lastEndpointField <= 4'h0;
      lastTx <= 1'b0;
      lastOdd <= 1'b0;
    end else if (wrDone) begin
      lastEndpointField <= curEp;
      lastTx <= curTx;
      lastOdd <= curOdd;
    end
  end

  // ----------------------------------------
  // Ping-pong pointers
  // ----------------------------------------
  ubd_ping_pong #(
    .NUM_EPS(NUM_EP)
  ) u_pp (
    .core_clk(core_clk),
    .srst(srst),
    .flush(ppFlush),
    .flip(wrDone && ppAble),
    .flipSel(ppSel),
    .oddBits(oddBits)
  );
endmodule

// *** hdl/ubd_index_map.sv ***
`timescale 1ns/1ns
module ubd_index_map
  import ubd_pkg::*;
(
  input wire ubd_pkg::ubd_pp_mode_t ppMode,
  input wire logic [3:0] ep,
  input wire logic tx,
  input wire logic odd,
  output logic [ubd_pkg::INDEX_W-1:0] index,
  output logic ppAble
);
  // ----------------------------------------
  // Per-mode descriptor index
  // ----------------------------------------
  wire epZero = (ep == 4'h0);
  wire [INDEX_W-1:0] idxMode0 = {1'b0, ep, tx};
  wire [INDEX_W-1:0] idxMode1 = epZero ? (tx ? 6'h02 : {5'h00, odd}) : ({1'b0, ep, 1'b1} + {5'h00, tx});
  wire [INDEX_W-1:0] idxMode2 = {ep, tx, odd};
  wire [INDEX_W-1:0] idxMode3 = epZero ? {5'h00, tx} : ({ep, tx, odd} - 6'h02);
  assign index = (ppMode == PP_NONE) ? idxMode0 :
                 (ppMode == PP_EP0_OUT) ? idxMode1 :
                 (ppMode == PP_ALL) ? idxMode2 : idxMode3;
  assign ppAble = (ppMode == PP_ALL) || ((ppMode == PP_EP0_OUT) && epZero && !tx) ||
                  ((ppMode == PP_ALL_BUT_EP0) && !epZero);
endmodule

// *** hdl/ubd_ping_pong.sv ***
`timescale 1ns/1ns
module ubd_ping_pong
  import ubd_pkg::*;
#(
  parameter int NUM_EPS = ubd_pkg::NUM_EP
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic flip,
  input wire logic [4:0] flipSel,
  output logic [2*NUM_EPS-1:0] oddBits
);
  // ----------------------------------------
  // Even/odd pointer per endpoint direction
  // ----------------------------------------
  if (NUM_EPS < 1 || NUM_EPS > 16) begin : g_check
    $error("ubd_ping_pong: NUM_EPS must be 1 to 16");
  end
  for (genvar i = 0; i < 2 * NUM_EPS; i++) begin : g_bit
    always_ff @(posedge core_clk) begin
      if (srst || flush) begin
        oddBits[i] <= 1'b0;
      end else if (flip && (flipSel == 5'(i))) begin
        oddBits[i] <= ~oddBits[i];
      end
    end
  end
endmodule

// *** hdl/ubd_pkg.sv ***
package ubd_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_TABLE_BASE = 8'h00;
  localparam logic [7:0] REG_CONFIG_ONE = 8'h01;
  localparam logic [7:0] REG_XFER_STATUS = 8'h02;
  localparam logic [7:0] REG_HOST_TOKEN = 8'h03;
  localparam logic [7:0] REG_STALL_FLAGS = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h05;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OWNER_POS = 15;
  localparam int TOGGLE_POS = 14;
  localparam int PID_LSB = 10;
  localparam int TOGGLE_CHECK_POS = 11;
  localparam int STALL_EN_POS = 10;
  localparam int CFG_HOST_POS = 2;
  localparam int CTRL_PP_RESET_POS = 0;
  // ----------------------------------------
  // Widths and geometry
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;
  localparam int COUNT_W = 10;
  localparam int INDEX_W = 6;
  localparam int NUM_EP = 16;
  localparam int TABLE_ALIGN_BITS = 9;
  localparam logic [ADDR_W-1:0] STATUS_WORD_OFS = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_WORD_OFS = 16'h0002;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] TABLE_BASE_RESET = 8'h00;
  localparam logic [2:0] CONFIG_RESET = 3'h0;
  localparam logic [7:0] HOST_TOKEN_RESET = 8'h00;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PP_NONE = 2'b00,
    PP_EP0_OUT = 2'b01,
    PP_ALL = 2'b10,
    PP_ALL_BUT_EP0 = 2'b11
  } ubd_pp_mode_t;
  typedef enum logic [1:0] {
    RESP_ACK = 2'b00,
    RESP_NAK = 2'b01,
    RESP_STALL = 2'b10,
    RESP_DROP = 2'b11
  } ubd_resp_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_STAT = 3'b001,
    ST_RD_ADDR = 3'b010,
    ST_RESP = 3'b011,
    ST_WAIT_DONE = 3'b100,
    ST_WR_STAT = 3'b101
  } ubd_state_t;
endpackage

// *** tb/tb_ubd_descriptor_engine.sv ***
`timescale 1ns/1ns
module tb_ubd_descriptor_engine;
  import ubd_pkg::*;
  logic core_clk = 0, srst = 1, regWr = 0, regRd = 0, tokReq = 0, tokTx = 0, tokToggle = 0, doneReq = 0;
  logic [7:0] regAddr = 8'h00, base;
  logic [15:0] regWdata = 16'h0000, regRdata, respBufAddr, memAddr, memWdata, memRdata, r;
  logic [3:0] tokEp = 4'h0, tokPid = 4'h0, donePid = 4'h0, hostTokenPid, hostTokenEp;
  logic [9:0] doneCount = 10'h000, respCount;
  logic respValid, respToggle, memReq, memWe, memAck, hostTokenGo, busy, host;
  logic [1:0] slow = 2'h0, ppm;
  logic oddS [32];
  logic [31:0] seed = 32'h464F;
  int fail_count = 0, checks = 0;
  ubd_resp_t respCode;
  always #4 core_clk = ~core_clk;
  ubd_descriptor_engine dut (.core_clk, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .tokReq,
    .tokEp, .tokTx, .tokPid, .tokToggle, .respValid, .respCode, .respBufAddr, .respCount, .respToggle,
    .doneReq, .doneCount, .donePid, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata,
    .hostTokenGo, .hostTokenPid, .hostTokenEp, .busy);
  ubd_mem_model u_mem (.core_clk, .slow, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic int bd_index(input logic [3:0] e, input logic t);
    int n = e;
    int o = oddS[{e, t}];
    case (ppm)
      2'd0: return 2 * n + t;
      2'd1: return (n == 0) ? (t ? 2 : o) : 2 * n + 1 + t;
      2'd2: return 4 * n + 2 * t + o;
      default: return (n == 0) ? t : 4 * n - 2 + 2 * t + o;
    endcase
  endfunction
  task automatic end_of_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
    d = regRdata;
  endtask
  task automatic xfer(input logic [3:0] ep, input logic tx, input logic tg, input logic [15:0] st,
    input ubd_resp_t ec);
    logic [3:0] e, pid, dp;
    logic [14:0] w;
    logic [15:0] ad, q;
    logic o;
    e = host ? 4'h0 : ep;
    o = oddS[{e, tx}];
    w = {base[7:1], 1'b0, 6'(bd_index(e, tx)), 1'b0};
    ad = rnd();
    q = rnd();
    pid = q[3:0];
    dp = q[7:4];
    slow <= q[9:8];
    for (int i = 0; i < 256; i++) u_mem.mem[{base[7:1], 8'(i)}] = 16'h0000;
    u_mem.mem[w] = st;
    u_mem.mem[w + 15'h1] = ad;
    if (host) wr(REG_HOST_TOKEN, {8'h00, pid, ep});
    @(posedge core_clk);
    if (host) chk({8'h00, hostTokenPid, hostTokenEp}, {8'h00, pid, ep});
    if (host) chk(16'(hostTokenGo), 16'h0001);
    tokReq <= 1'b1;
    tokEp <= ep;
    tokTx <= tx;
    tokPid <= pid;
    tokToggle <= tg;
    @(posedge core_clk);
    tokReq <= 1'b0;
    for (int i = 0; i < 40 && respValid !== 1'b1; i++) @(posedge core_clk);
    chk(16'(respCode), 16'(ec));
    if (ec == RESP_ACK) begin
      chk(respBufAddr, ad);
      chk({5'h00, respToggle, respCount}, {5'h00, st[14], st[9:0]});
      @(posedge core_clk);
      doneReq <= 1'b1;
      doneCount <= q[15:6];
      donePid <= dp;
      @(posedge core_clk);
      doneReq <= 1'b0;
    end
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge core_clk);
    if (ec == RESP_ACK) begin
      chk(u_mem.mem[w], {1'b0, tg, host ? dp : pid, q[15:6]});
      if ((ppm == 2'd1 && e == 0 && !tx) || ppm == 2'd2 || (ppm == 2'd3 && e != 0)) oddS[{e, tx}] = ~o;
      rd(REG_XFER_STATUS, q);
      chk(q & 16'h00FC, {8'h00, ep, tx, o, 2'b00});
    end else begin
      chk(u_mem.mem[w], st);
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd(REG_TABLE_BASE, r);
    chk(r, 16'(TABLE_BASE_RESET));
    wr(8'h3C, 16'hFFFF);
    rd(8'h3C, r);
    chk(r, 16'h0000);
    r = rnd();
    base = r[7:0] | 8'h01;
    wr(REG_TABLE_BASE, {8'h00, base});
    rd(REG_TABLE_BASE, r);
    chk(r, {8'h00, base});
    $display("register tests done");
    for (int m = 0; m < 8; m++) begin
      ppm = m[1:0];
      host = m[2];
      wr(REG_CONFIG_ONE, {13'h0000, host, ppm});
      wr(REG_CONTROL, 16'h0001);
      oddS = '{default: 1'b0};
      for (int k = 0; k < 12; k++) begin
        r = rnd();
        xfer(k == 0 ? 4'hF : r[3:0], r[4], r[5], {1'b1, r[6], 4'h0, r[15:6]}, RESP_ACK);
      end
      $display("mode %0d host %0d done", ppm, host);
    end
    host = 1'b0;
    ppm = 2'd2;
    wr(REG_CONFIG_ONE, 16'h0002);
    xfer(4'h5, 1'b1, 1'b0, 16'h4123, RESP_NAK);
    xfer(4'h9, 1'b0, 1'b0, 16'h8404, RESP_STALL);
    rd(REG_STALL_FLAGS, r);
    chk(r, 16'h0200);
    wr(REG_STALL_FLAGS, 16'hFFFF);
    rd(REG_STALL_FLAGS, r);
    chk(r, 16'h0000);
    xfer(4'h3, 1'b0, 1'b1, 16'h8810, RESP_DROP);
    xfer(4'h3, 1'b0, 1'b1, 16'hC810, RESP_ACK);
    $display("corner cases done");
    end_of_test;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    end_of_test;
  end
endmodule

// *** tb/ubd_descriptor_engine_assertions.sv ***
`timescale 1ns/1ns
module ubd_engine_checker
  import ubd_pkg::*;
(
  input logic core_clk,
  input logic srst,
  input logic [7:0] regAddr,
  input logic [15:0] regWdata,
  input logic regWr,
  input logic regRd,
  input logic [15:0] regRdata,
  input logic tokReq,
  input logic respValid,
  input ubd_pkg::ubd_resp_t respCode,
  input logic memReq,
  input logic memWe,
  input logic [15:0] memAddr,
  input logic [15:0] memWdata,
  input logic memAck,
  input logic hostTokenGo,
  input logic [3:0] hostTokenPid,
  input logic [3:0] hostTokenEp,
  input logic busy
);
  logic [6:0] baseHi;
  logic [2:0] cfg;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      baseHi <= 7'h00;
      cfg <= 3'h0;
    end else if (regWr && regAddr == REG_TABLE_BASE) begin
      baseHi <= regWdata[7:1];
    end else if (regWr && regAddr == REG_CONFIG_ONE) begin
      cfg <= regWdata[2:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  rd_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data not zero outside read");
  resp_pulse_a: assert property (respValid |=> !respValid)
    else $error("response longer than one cycle");
  mem_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
    else $error("memory request changed before ack");
  mem_release_a: assert property (memReq && memAck |=>
    !memReq || (!memWe && memAddr == $past(memAddr) + 16'h0002))
    else $error("memory request held after ack");
  table_region_a: assert property (memReq |-> memAddr[15:9] == baseHi)
    else $error("access outside table region");
  host_ep_zero_a: assert property (memReq && cfg == 3'h4 |-> memAddr[8:3] == 6'h00)
    else $error("host mode used non zero endpoint descriptor");
  token_start_a: assert property (tokReq && !busy |=> busy && memReq && !memWe && memAddr[1:0] == 2'b00)
    else $error("token did not read status word");
  writeback_form_a: assert property (memReq && memWe |-> !memWdata[OWNER_POS] && memAddr[1:0] == 2'b00)
    else $error("write back not to status word or owner kept");
  resp_follow_a: assert property (memAck && !memWe |-> ##[1:2] (respValid || memReq))
    else $error("read ack not followed");
  host_token_a: assert property (regWr && regAddr == REG_HOST_TOKEN |=>
    hostTokenGo && {hostTokenPid, hostTokenEp} == $past(regWdata[7:0]))
    else $error("host token not issued");
  cover property (respValid && respCode == RESP_STALL);
  cover property (respValid && respCode == RESP_DROP);
  cover property (memReq && memWe && memAck);
  cover property (hostTokenGo);
endmodule
bind ubd_descriptor_engine ubd_engine_checker u_chk (.core_clk, .srst, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .tokReq, .respValid, .respCode, .memReq, .memWe, .memAddr, .memWdata, .memAck, .hostTokenGo,
  .hostTokenPid, .hostTokenEp, .busy);

// *** tb/ubd_mem_model.sv ***
`timescale 1ns/1ns
module ubd_mem_model (
  input wire logic core_clk,
  input wire logic [1:0] slow,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic memAck,
  output logic [15:0] memRdata
);
  logic [15:0] mem [0:32767];
  logic [1:0] waitCnt = 2'h0;
  initial memAck = 1'b0;
  initial memRdata = 16'hA5A5;
  always @(posedge core_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck) begin
      if (waitCnt == slow) begin
        waitCnt <= 2'h0;
        memAck <= 1'b1;
        memRdata <= mem[memAddr[15:1]];
        if (memWe) begin
          mem[memAddr[15:1]] <= memWdata;
        end
      end else begin
        waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule
